//--- design/nand_host_pkg.sv
/*
 * Constants shared by the NAND flash host controller: pin timing, address
 * layout, request op codes and state codes.
 * Assumes a single 250 MHz clock and a device with an x8 or x16 I/O bus.
 */
// Function
// - Commands, addresses and data share one two-way bus, 8 or 16 lines.
// - Command latch enable high makes the strobed value a command.
// - Address latch enable high makes the strobed value an address cycle.
// - Host should keep write protect low through power-up and power-down.
// - Ready/busy is open-drain; host pulls it up and may wire-OR devices.
// - Protect pin high at power-on protects all blocks until unprotected.
// - Full address is four cycles: two column cycles then two row cycles.
// - Byte bus: column 7..0, 11..8 upper low, rows 19..12 and 27..20.
// - Word bus: column 7..0, 10..8, rows 18..11, 26..19; rest driven low.
// - Host clocks no read data until ready/busy has returned to ready.
package nand_host_pkg;

    localparam int CLK_MHZ = 250;

    // Strobe timing in ns and derived cycle counts (least times, round up)
    localparam int T_WE_LOW_NS = 12;
    localparam int T_WE_HIGH_NS = 10;
    localparam int T_RE_LOW_NS = 12;
    localparam int T_RE_HIGH_NS = 10;
    localparam int T_REA_NS = 20;
    // Sync flops, agreement flop and a change landing on an edge
    localparam int SYNC_LAT_CYC = 5;
    localparam int WE_LOW_CYC = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int WE_HIGH_CYC = (T_WE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int RE_HIGH_CYC = (T_RE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int REA_CYC = (T_REA_NS * CLK_MHZ + 999) / 1000;
    localparam int RE_LOW_MIN_CYC = (T_RE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int RE_LOW_CYC = (REA_CYC + SYNC_LAT_CYC > RE_LOW_MIN_CYC) ?
        REA_CYC + SYNC_LAT_CYC : RE_LOW_MIN_CYC;

    localparam logic [7:0] WE_LOW_CNT = 8'(WE_LOW_CYC - 1);
    localparam logic [7:0] WE_HIGH_CNT = 8'(WE_HIGH_CYC - 1);
    localparam logic [7:0] RE_LOW_CNT = 8'(RE_LOW_CYC - 1);
    localparam logic [7:0] RE_HIGH_CNT = 8'(RE_HIGH_CYC - 1);

    // Bus and page geometry
    localparam int IO_W = 16;
    localparam int COL_W = 12;
    localparam int ROW_W = 16;
    localparam int CNT_W = 12;
    localparam int PAGE_MAIN_BYTES = 2048;
    localparam int PAGE_SPARE_BYTES = 64;
    localparam int PAGE_MAIN_WORDS = 1024;
    localparam int PAGE_SPARE_WORDS = 32;
    localparam int PAGES_PER_BLOCK = 64;
    localparam int ADDR_CYCLES = 4;
    localparam logic [1:0] ADDR_LAST = 2'h3;
    localparam int FIFO_DEPTH = 4;

    // Reset values of pin outputs
    localparam logic CE_N_RST = 1'b1;
    localparam logic WP_N_RST = 1'b0;
    localparam logic PROTECT_RST = 1'b0;

    typedef enum logic [2:0] {
        OP_CMD = 3'b000,
        OP_ADDR = 3'b001,
        OP_DIN = 3'b010,
        OP_DOUT = 3'b011,
        OP_WAIT = 3'b100
    } op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_WAIT = 3'b001,
        S_WE_LO = 3'b010,
        S_WE_HI = 3'b011,
        S_RE_LO = 3'b100,
        S_RE_HI = 3'b101
    } state_t;

endpackage : nand_host_pkg

//--- design/pin_sync.sv
/*
 * Three-flop synchroniser for pin inputs with an agreement filter.
 * Assumes inputs come from outside the CLK domain.
 */
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [WIDTH-1:0] PIN,
    input wire logic [WIDTH-1:0] RST_VAL,
    output logic [WIDTH-1:0] LEVEL
);
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] agree;

    assign agree = ~(ff2 ^ ff3);

    always_ff @(posedge CLK) begin
        ff1 <= PIN;
        ff2 <= ff1;
        ff3 <= ff2;
    end

    // A change counts once the second and third flops agree
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            LEVEL <= RST_VAL;
        end else begin
            LEVEL <= (agree & ff3) | (~agree & LEVEL);
        end
    end
endmodule : pin_sync

//--- design/word_fifo.sv
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two.
 */
`timescale 1ns/1ns
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [WIDTH-1:0] IN_DATA,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [WIDTH-1:0] OUT_DATA
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign IN_READY = (count != (AW+1)'(DEPTH));
    assign OUT_VALID = (count != '0);
    assign OUT_DATA = mem[rd_ptr];
    assign push = IN_VALID & IN_READY;
    assign pop = OUT_VALID & OUT_READY;

    always_ff @(posedge CLK) begin
        if (push) begin
            mem[wr_ptr] <= IN_DATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : word_fifo

//--- design/nand_host.sv
/*
 * NAND flash host controller: runs command, address, data-in and data-out
 * requests as strobe sequences on the device pins; wait requests only wait for ready.
 * Assumes an external pull-up on the ready/busy line and the bus resolved
 * from IO_BUS_OUT and IO_BUS_OE_N by the surroundings.
 */
`timescale 1ns/1ns
module nand_host
    import nand_host_pkg::*;
#(
    parameter bit WORD_WIDE = 1'b0
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic [2:0] REQ_OP,
    input wire logic [15:0] REQ_DATA,
    input wire logic [COL_W-1:0] REQ_COL,
    input wire logic [ROW_W-1:0] REQ_ROW,
    input wire logic [CNT_W-1:0] REQ_COUNT,
    output logic RD_VALID,
    input wire logic RD_READY,
    output logic [15:0] RD_DATA,
    input wire logic WRITE_ALLOW,
    input wire logic PROTECT_ALL,
    output logic BUSY,
    output logic CHIP_SELECT_N,
    output logic CMD_LATCH,
    output logic ADDR_LATCH,
    output logic WRITE_STROBE_N,
    output logic READ_STROBE_N,
    output logic WRITE_PROTECT_N,
    output logic WHOLE_CHIP_PROTECT,
    output logic [IO_W-1:0] IO_BUS_OUT,
    output logic IO_BUS_OE_N,
    input wire logic [IO_W-1:0] IO_BUS_IN,
    input wire logic READY_BUSY_N
);
    ////////////////////////////////////////////////////////////////////////
    // Address cycle mapping
    function automatic logic [15:0] addr_word(
        input logic wide,
        input logic [COL_W-1:0] col,
        input logic [ROW_W-1:0] row,
        input logic [1:0] idx
    );
        logic [15:0] w;
        w = 16'h0000;
        case (idx)
            2'h0: w = {8'h00, col[7:0]};
            2'h1: w = wide ? {13'h0000, col[10:8]}
                           : {12'h000, col[11:8]};
            2'h2: w = {8'h00, row[7:0]};
            2'h3: w = {8'h00, row[15:8]};
            default: w = 16'h0000;
        endcase
        return w;
    endfunction : addr_word

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic rb_level;
    logic [IO_W-1:0] io_level;

    pin_sync #(.WIDTH(1)) u_rb_sync (
        .CLK(CLK),
        .RST_B(RST_B),
        .PIN(READY_BUSY_N),
        .RST_VAL(1'b1),
        .LEVEL(rb_level)
    );

    pin_sync #(.WIDTH(IO_W)) u_io_sync (
        .CLK(CLK),
        .RST_B(RST_B),
        .PIN(IO_BUS_IN),
        .RST_VAL(16'h0000),
        .LEVEL(io_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data buffer
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [15:0] fifo_in_data;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;

    word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
        .CLK(CLK),
        .RST_B(RST_B),
        .IN_VALID(fifo_in_valid),
        .IN_READY(fifo_in_ready),
        .IN_DATA(fifo_in_data),
        .OUT_VALID(fifo_out_valid),
        .OUT_READY(RD_READY),
        .OUT_DATA(fifo_out_data)
    );

    assign RD_VALID = fifo_out_valid;
    assign RD_DATA = fifo_out_data;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    state_t state;
    state_t next_state;
    logic [2:0] op;
    logic [7:0] timer;
    logic [1:0] addr_idx;
    logic [CNT_W-1:0] remain;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
    logic [15:0] wdata;

    logic timer_done;
    logic take_req;
    logic addr_more;
    logic read_more;
    logic [15:0] drive_word;
    logic [15:0] read_word;
    logic [7:0] next_timer;

    assign timer_done = (timer == 8'h00);
    assign take_req = REQ_VALID & REQ_READY;
    assign addr_more = (op == OP_ADDR) && (addr_idx != ADDR_LAST);
    assign read_more = (remain != '0);
    assign drive_word = (op == OP_ADDR) ? addr_word(WORD_WIDE, col, row,
        addr_idx) : wdata;
    // Byte bus ignores upper lanes
    assign read_word = WORD_WIDE ? io_level : {8'h00, io_level[7:0]};
    assign fifo_in_data = read_word;
    // Capture at the end of the read strobe low phase
    assign fifo_in_valid = (state == S_RE_LO) && timer_done;

    always_comb begin
        next_state = state;
        next_timer = timer_done ? 8'h00 : timer - 8'h01;
        case (state)
            S_IDLE: begin
                if (take_req) begin
                    case (REQ_OP)
                        OP_CMD, OP_ADDR, OP_DIN: begin
                            next_state = S_WE_LO;
                            next_timer = WE_LOW_CNT;
                        end
                        OP_DOUT, OP_WAIT: begin
                            next_state = S_WAIT;
                        end
                        default: begin
                            next_state = S_IDLE;
                        end
                    endcase
                end
            end
            S_WAIT: begin
                // Leave only once ready/busy reads ready
                if (rb_level) begin
                    if (op == OP_DOUT && read_more && fifo_in_ready) begin
                        next_state = S_RE_LO;
                        next_timer = RE_LOW_CNT;
                    end else if (op != OP_DOUT || !read_more) begin
                        next_state = S_IDLE;
                    end
                end
            end
            S_WE_LO: begin
                if (timer_done) begin
                    next_state = S_WE_HI;
                    next_timer = WE_HIGH_CNT;
                end
            end
            S_WE_HI: begin
                if (timer_done && addr_more) begin
                    next_state = S_WE_LO;
                    next_timer = WE_LOW_CNT;
                end else if (timer_done) begin
                    next_state = S_IDLE;
                end
            end
            S_RE_LO: begin
                if (timer_done) begin
                    next_state = S_RE_HI;
                    next_timer = RE_HIGH_CNT;
                end
            end
            S_RE_HI: begin
                // Back-pressure from the buffer holds the strobe high
                if (timer_done && !read_more) begin
                    next_state = S_IDLE;
                end else if (timer_done && fifo_in_ready) begin
                    next_state = S_RE_LO;
                    next_timer = RE_LOW_CNT;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            state <= S_IDLE;
            timer <= 8'h00;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            op <= OP_CMD;
            addr_idx <= 2'h0;
            remain <= '0;
            col <= '0;
            row <= '0;
            wdata <= 16'h0000;
        end else if (take_req) begin
            op <= REQ_OP;
            addr_idx <= 2'h0;
            remain <= REQ_COUNT;
            col <= REQ_COL;
            row <= REQ_ROW;
            // Byte bus keeps upper lanes low
            wdata <= WORD_WIDE ? REQ_DATA : {8'h00, REQ_DATA[7:0]};
        end else begin
            if (state == S_WE_HI && timer_done && addr_more) begin
                addr_idx <= addr_idx + 2'h1;
            end
            if (fifo_in_valid) begin
                remain <= remain - CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs, all registered
    logic we_phase;
    logic next_oe_n;

    assign we_phase = (next_state == S_WE_LO) || (next_state == S_WE_HI);
    assign next_oe_n = ~we_phase;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            CHIP_SELECT_N <= CE_N_RST;
            CMD_LATCH <= 1'b0;
            ADDR_LATCH <= 1'b0;
            WRITE_STROBE_N <= 1'b1;
            READ_STROBE_N <= 1'b1;
            IO_BUS_OUT <= 16'h0000;
            IO_BUS_OE_N <= 1'b1;
        end else begin
            // Deselect between requests so an idle device can rest
            CHIP_SELECT_N <= (next_state == S_IDLE);
            // Only one latch enable at a time; neither means data
            CMD_LATCH <= we_phase && (take_req ? REQ_OP == OP_CMD
                                               : op == OP_CMD);
            ADDR_LATCH <= we_phase && (take_req ? REQ_OP == OP_ADDR
                                                : op == OP_ADDR);
            // Bus stays steady across the rising strobe edge
            WRITE_STROBE_N <= (next_state != S_WE_LO);
            READ_STROBE_N <= (next_state != S_RE_LO);
            IO_BUS_OUT <= take_req ? 16'h0000 : drive_word;
            IO_BUS_OE_N <= next_oe_n;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            REQ_READY <= 1'b0;
            BUSY <= 1'b0;
            WRITE_PROTECT_N <= WP_N_RST;
            WHOLE_CHIP_PROTECT <= PROTECT_RST;
        end else begin
            REQ_READY <= (next_state == S_IDLE) && !take_req;
            BUSY <= ~rb_level;
            // Protect held until software allows writes
            WRITE_PROTECT_N <= WRITE_ALLOW;
            WHOLE_CHIP_PROTECT <= PROTECT_ALL;
        end
    end
endmodule : nand_host

//--- verification/nand_dev_model.sv
/*
 * Behavioural x8 NAND device facing the host controller's pins.
 * Assumes the bench resolves the shared bus and pulls ready/busy up.
 */
`timescale 1ns/1ns
module nand_dev_model #(
    parameter int ACC_NS = 16,
    parameter int BUSY_NS = 400
) (
    input wire logic cs_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic wp_n,
    input wire logic pt,
    input wire logic [15:0] io,
    output logic [15:0] io_drv,
    output logic rb_low
);
    logic [7:0] last_cmd;
    logic [31:0] adr;
    logic [15:0] last_din;
    logic [11:0] col, rcol;
    logic [1:0] acnt;
    logic locked, standby;
    int n_prog, n_refused;
    event go_busy;
    logic [9:0] prog_blk;
    localparam int PAGE_BYTES = 2048 + 64;
    ////////////////////////////////////////
    initial begin
        {last_cmd, adr, last_din, col, acnt} = '0;
        io_drv = 16'h5555;
        rb_low = 1'b0;
        {n_prog, n_refused} = '0;
        #20 locked = (pt === 1'b1);
    end
    assign standby = cs_n && !rb_low;
    always @(posedge we_n) begin
        if (!cs_n && cle) begin
            last_cmd = io[7:0];
            acnt = 2'h0;
            if (io[7:0] == 8'h30) begin
                ->go_busy;
            end
            if (io[7:0] == 8'h10 || io[7:0] == 8'hd0) begin
                if (wp_n && !locked) begin
                    n_prog++;
                    prog_blk = adr[31:22];
                    ->go_busy;
                end else begin
                    n_refused++;
                end
            end
        end else if (!cs_n && ale) begin
            adr[8*acnt +: 8] = io[7:0];
            col = (acnt == 2'h1) ? adr[11:0] : col;
            acnt++;
        end else if (!cs_n) begin
            last_din = io;
        end
    end
    always @(go_busy) begin
        rb_low = 1'b1;
        #BUSY_NS rb_low = 1'b0;
    end
    always @(negedge re_n) begin
        if (!cs_n) begin
            rcol = col;
            col = (col == 12'(PAGE_BYTES - 1)) ? 12'h000 : col + 12'h1;
            #ACC_NS io_drv = {~rcol[7:0], rcol[7:0] ^ 8'ha5};
        end
    end
    always @(posedge re_n) begin
        #1 io_drv = ~io_drv;
    end
endmodule : nand_dev_model

//--- verification/nand_host_props.sv
/*
 * Pin-level checks of the NAND host controller, bound to its top.
 * Assumes one clock domain and the bus width set by WORD_WIDE.
 */
`timescale 1ns/1ns
module nand_host_props
    import nand_host_pkg::*;
#(
    parameter bit WORD_WIDE = 1'b0
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic REQ_VALID,
    input wire logic REQ_READY,
    input wire logic WRITE_ALLOW,
    input wire logic BUSY,
    input wire logic CHIP_SELECT_N,
    input wire logic CMD_LATCH,
    input wire logic ADDR_LATCH,
    input wire logic WRITE_STROBE_N,
    input wire logic READ_STROBE_N,
    input wire logic WRITE_PROTECT_N,
    input wire logic [IO_W-1:0] IO_BUS_OUT,
    input wire logic IO_BUS_OE_N,
    input wire logic READY_BUSY_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    ////////////////////////////////////////
    a_latch_excl: assert property (!(CMD_LATCH && ADDR_LATCH))
        else $error("both latch enables high");
    a_we_low_len: assert property ($fell(WRITE_STROBE_N) |->
        !WRITE_STROBE_N [*3] ##1 WRITE_STROBE_N)
        else $error("write strobe low time wrong");
    a_bus_held: assert property ($rose(WRITE_STROBE_N) |->
        !IO_BUS_OE_N && $stable(IO_BUS_OUT) && $stable(CMD_LATCH)
        && $stable(ADDR_LATCH))
        else $error("bus moved at write strobe rise");
    a_re_low_len: assert property ($fell(READ_STROBE_N) |->
        !READ_STROBE_N [*8] ##1 !READ_STROBE_N [*2] ##1 READ_STROBE_N)
        else $error("read strobe low time wrong");
    a_re_ready: assert property ($fell(READ_STROBE_N) |->
        READY_BUSY_N && !BUSY)
        else $error("read strobe while busy");
    a_re_bus_free: assert property (!READ_STROBE_N |->
        IO_BUS_OE_N && WRITE_STROBE_N && !CHIP_SELECT_N)
        else $error("bus driven during read strobe");
    a_upper_low: assert property (!IO_BUS_OE_N && !WORD_WIDE |->
        IO_BUS_OUT[15:8] == 8'h00)
        else $error("upper lanes not low");
    a_busy_seen: assert property ($fell(READY_BUSY_N) |->
        ##[1:5] BUSY)
        else $error("busy not reported");
    a_wp_follow: assert property ($past(RST_B) |->
        WRITE_PROTECT_N == $past(WRITE_ALLOW))
        else $error("write protect does not follow");
    a_idle_desel: assert property (REQ_READY |-> CHIP_SELECT_N)
        else $error("chip selected while idle");
    c_take: cover property (REQ_VALID && REQ_READY);
    c_addr: cover property (ADDR_LATCH && !WRITE_STROBE_N);
    c_read: cover property ($fell(READ_STROBE_N));
endmodule : nand_host_props
bind nand_host nand_host_props #(.WORD_WIDE(WORD_WIDE)) props (
    .CLK, .RST_B, .REQ_VALID, .REQ_READY, .WRITE_ALLOW, .BUSY,
    .CHIP_SELECT_N, .CMD_LATCH, .ADDR_LATCH, .WRITE_STROBE_N,
    .READ_STROBE_N, .WRITE_PROTECT_N, .IO_BUS_OUT, .IO_BUS_OE_N,
    .READY_BUSY_N
);

//--- verification/tb_top.sv
/*
 * Self-checking bench of the NAND host controller with an x8 device model.
 * Assumes the package, design and device model are compiled before it.
 */
`timescale 1ns/1ns
module tb_top
    import nand_host_pkg::*;
;
    typedef struct packed {
        logic [2:0] op;
        logic [15:0] data;
        logic [11:0] col;
        logic [15:0] row;
        logic [31:0] exp;
    } row_t;
    row_t rows [7];
    logic clk, rst_b, req_valid, req_ready, rd_valid, rd_ready, busy;
    logic write_allow, protect_all, cs_n, cle, ale, we_n, re_n, wp_n, pt;
    logic oe_n, rb_n, rb_low;
    logic [2:0] req_op;
    logic [11:0] req_col, req_count, ecol;
    logic [15:0] req_data, req_row, rd_data, io_out, dev_io, io;
    logic [31:0] got;
    int err_total, n_compared, cyc;
    assign io = oe_n ? dev_io : io_out;
    assign rb_n = !rb_low;
    ////////////////////////////////////////
    nand_host #(.WORD_WIDE(1'b0)) dut (
        .CLK(clk), .RST_B(rst_b), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ_OP(req_op), .REQ_DATA(req_data),
        .REQ_COL(req_col), .REQ_ROW(req_row), .REQ_COUNT(req_count),
        .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data),
        .WRITE_ALLOW(write_allow), .PROTECT_ALL(protect_all),
        .BUSY(busy), .CHIP_SELECT_N(cs_n), .CMD_LATCH(cle),
        .ADDR_LATCH(ale), .WRITE_STROBE_N(we_n), .READ_STROBE_N(re_n),
        .WRITE_PROTECT_N(wp_n), .WHOLE_CHIP_PROTECT(pt),
        .IO_BUS_OUT(io_out), .IO_BUS_OE_N(oe_n), .IO_BUS_IN(io),
        .READY_BUSY_N(rb_n)
    );
    nand_dev_model dev (.cs_n, .cle, .ale, .we_n, .re_n, .wp_n, .pt,
        .io, .io_drv(dev_io), .rb_low);
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done;
        end
    end
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_bit(input string nm, input logic e, g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    task automatic wait_idle;
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
    endtask : wait_idle
    task automatic send(input logic [2:0] op, input logic [15:0] d,
            input logic [11:0] c, input logic [15:0] r, input logic [11:0] n);
        @(negedge clk);
        {req_op, req_data, req_col, req_row, req_count} = {op, d, c, r, n};
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
    endtask : send
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////
    initial begin
        {clk, rst_b, req_valid, rd_ready, write_allow, protect_all} = '0;
        {req_op, req_data, req_col, req_row, req_count} = '0;
        {err_total, n_compared, cyc} = '0;
        rows = '{
            '{OP_CMD, 16'h0000, 12'h000, 16'h0000, 32'h0000_0000},
            '{OP_ADDR, 16'h0000, 12'hfff, 16'h0000, 32'h0000_0fff},
            '{OP_ADDR, 16'h0000, 12'h0a5, 16'hc35a, 32'hc35a_00a5},
            '{OP_CMD, 16'h0080, 12'h000, 16'h0000, 32'h0000_0080},
            '{OP_DIN, 16'h1234, 12'h000, 16'h0000, 32'h0000_0034},
            '{OP_CMD, 16'h0070, 12'h000, 16'h0000, 32'h0000_0070},
            '{OP_DIN, 16'hffff, 12'h000, 16'h0000, 32'h0000_00ff}};
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        foreach (rows[i]) begin
            send(rows[i].op, rows[i].data, rows[i].col, rows[i].row, 12'h0);
            wait_idle;
            got = rows[i].op == OP_CMD ? {24'h0, dev.last_cmd} :
                rows[i].op == OP_ADDR ? dev.adr : {16'h0, dev.last_din};
            chk("captured", rows[i].exp, got);
        end
        $display("test rows done");
        send(OP_ADDR, 16'h0000, 12'h7fe, 16'h0101, 12'h0);
        wait_idle;
        send(OP_CMD, 16'h0030, 12'h0, 16'h0, 12'h0);
        wait_idle;
        repeat (10) @(negedge clk);
        chk_bit("busy read", 1'b1, busy);
        send(OP_DOUT, 16'h0, 12'h0, 16'h0, 12'h6);
        repeat (250) @(negedge clk);
        chk("column", 32'h802, {20'h0, dev.col});
        chk_bit("fifo full", 1'b1, rd_valid);
        rd_ready = 1'b1;
        for (int i = 0; i < 6; i++) begin
            while (rd_valid !== 1'b1) @(negedge clk);
            ecol = 12'h7fe + 12'(i);
            chk("read data", {24'h0, ecol[7:0] ^ 8'ha5}, rd_data);
            @(negedge clk);
        end
        rd_ready = 1'b0;
        wait_idle;
        chk_bit("drained", 1'b0, rd_valid);
        $display("test read done");
        send(OP_CMD, 16'h0010, 12'h0, 16'h0, 12'h0);
        wait_idle;
        chk("refused", 32'd1, dev.n_refused);
        write_allow = 1'b1;
        send(OP_CMD, 16'h0010, 12'h0, 16'h0, 12'h0);
        wait_idle;
        chk_bit("unprotected", 1'b1, wp_n);
        chk("programs", 32'd1, dev.n_prog);
        chk("block", 32'd4, {22'h0, dev.prog_blk});
        repeat (8) @(negedge clk);
        chk_bit("busy program", 1'b1, busy);
        chk_bit("no standby", 1'b0, dev.standby);
        send(OP_WAIT, 16'h0, 12'h0, 16'h0, 12'h0);
        wait_idle;
        chk_bit("ready", 1'b0, busy);
        chk_bit("standby", 1'b1, dev.standby);
        protect_all = 1'b1;
        repeat (2) @(negedge clk);
        chk_bit("chip protect", 1'b1, pt);
        $display("test protect done");
        rst_b = 1'b0;
        repeat (5) @(negedge clk);
        chk_bit("reset select", 1'b1, cs_n);
        chk_bit("reset protect", 1'b0, wp_n);
        chk_bit("reset bus", 1'b1, oe_n);
        rst_b = 1'b1;
        wait_idle;
        $display("test reset done");
        test_done;
    end
endmodule : tb_top
